// ==== design/cfg_serial_port.sv ====
// Write-only three-wire configuration port with per-side timeslot counters
//
// Operation
// (R1) The host writes zeros into the two top bits of both timeslot bytes.
// (R2) The input slot number is the low six bits of the input timeslot byte, bit five first in weight.
// (R3) The output slot number is the low six bits of the output timeslot byte, bit five first in weight.
// (R4) A write lasts from select falling to select rising, and bits are taken only while select is low.
// (R5) One data bit is taken on each rising serial clock edge inside a write.
// (R6) The host sends each byte least significant bit first.
// (R7) A write carries two bytes or four bytes, and both lengths are accepted.
// (R8) The host should end a write on a byte boundary.
// (R9) Both sample outputs float while a register update is in progress.
// (R10) Each frame sync pulse is no wider than one bit clock period.
// (R11) The first byte's address bits are compared with the straps and a mismatch ignores the rest.
// (R12) Bit six of the first byte picks side a on one and side b on zero.
// (R13) After a match the following bytes load control, input slot and output slot in order.
// (R14) Slots count from each frame sync rise, eight bits wide when compressing, four when expanding.
// (R15) A byte cut short by select rising is dropped and changes no register.
`timescale 1ns/1ps
module cfg_serial_port
    import adpcm_cfg_pkg::*;
(
    input  wire logic             sys_clk,
    input  wire logic             arst_n,
    input  wire logic             cfg_select_n,
    input  wire logic             cfg_serial_clk,
    input  wire logic             serial_config_in,
    input  wire logic [5:0]       strap_addr,
    input  wire logic             side_a_bit_clock,
    input  wire logic             side_b_bit_clock,
    input  wire logic             side_a_frame_sync,
    input  wire logic             side_b_frame_sync,
    input  wire logic             side_a_tx_bit,
    input  wire logic             side_b_tx_bit,
    output logic                  side_a_serial_out,
    output logic                  side_a_serial_oe,
    output logic                  side_b_serial_out,
    output logic                  side_b_serial_oe,
    output side_cfg_t [1:0]       side_cfg,
    output logic [1:0]            in_slot_hit,
    output logic [1:0]            out_slot_hit,
    output logic                  update_busy
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [SYNC_W-1:0] sync1_ff;
    logic [SYNC_W-1:0] sync2_ff;
    logic [SYNC_W-1:0] prev_ff;
    wire  [SYNC_W-1:0] pin_raw = {strap_addr, side_a_frame_sync, side_b_frame_sync,
                                  side_a_bit_clock, side_b_bit_clock,
                                  serial_config_in, cfg_serial_clk, cfg_select_n};

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_ff <= SYNC_RESET;
            sync2_ff <= SYNC_RESET;
            prev_ff  <= SYNC_RESET;
        end else begin
            sync1_ff <= pin_raw;
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    wire             sel_low    = ~sync2_ff[SY_SEL];
    wire             sel_rise   = sync2_ff[SY_SEL] & ~prev_ff[SY_SEL];
    wire             sclk_rise  = sync2_ff[SY_SCLK] & ~prev_ff[SY_SCLK];
    wire             sdi_bit    = sync2_ff[SY_SDI];
    wire [5:0]       strap_sync = sync2_ff[SY_STRAP +: ADDR_W];
    wire [1:0]       bclk_rise  = {sync2_ff[SY_CLK_A] & ~prev_ff[SY_CLK_A],
                                   sync2_ff[SY_CLK_B] & ~prev_ff[SY_CLK_B]};
    wire [1:0]       fs_level   = {sync2_ff[SY_FS_A], sync2_ff[SY_FS_B]};
    wire [1:0]       tx_bit     = {side_a_tx_bit, side_b_tx_bit};

    // ------------------------------------------------------------
    // Byte assembly
    // ------------------------------------------------------------
    port_state_t      state_ff;
    port_state_t      nxt_state;
    logic [2:0]       bit_cnt_ff;
    logic [7:0]       shift_ff;
    logic             sel_side_ff;

    // (R4) capture gate
    wire             take_bit   = sel_low & sclk_rise;
    wire             byte_done  = take_bit & (bit_cnt_ff == BIT_LAST);
    // (R6) first bit lands in bit zero
    wire [7:0]       full_byte  = {sdi_bit, shift_ff[7:1]};
    wire             addr_match = (full_byte[ADDR_W-1:0] == strap_sync);
    wire             wr_ctrl    = byte_done & (state_ff == ST_CTRL);
    wire             wr_in      = byte_done & (state_ff == ST_IN);
    wire             wr_out     = byte_done & (state_ff == ST_OUT);

    // (R5) one bit per serial clock rise
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            bit_cnt_ff <= 3'h0;
            shift_ff   <= 8'h00;
        end else if (!sel_low) begin
            bit_cnt_ff <= 3'h0;
            shift_ff   <= 8'h00;
        end else if (take_bit) begin
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
            shift_ff   <= full_byte;
        end
    end

    // (R7) two or four bytes, extra bytes ignored
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: if (sel_low) begin
                nxt_state = ST_ADDR;
            end
            // (R11) address compare
            ST_ADDR: if (byte_done) begin
                nxt_state = addr_match ? ST_CTRL : ST_SKIP;
            end
            // (R13) byte order
            ST_CTRL: if (byte_done) begin
                nxt_state = ST_IN;
            end
            ST_IN:   if (byte_done) begin
                nxt_state = ST_OUT;
            end
            ST_OUT:  if (byte_done) begin
                nxt_state = ST_SKIP;
            end
            ST_SKIP: nxt_state = ST_SKIP;
            default: nxt_state = ST_IDLE;
        endcase
        if (!sel_low) begin
            nxt_state = ST_IDLE;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff    <= ST_IDLE;
            sel_side_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            // (R12) side select bit
            if (byte_done && state_ff == ST_ADDR) begin
                sel_side_ff <= full_byte[ACB_SIDE_BIT];
            end
        end
    end

    // (R9) update window
    assign update_busy = (state_ff == ST_CTRL) | (state_ff == ST_IN) | (state_ff == ST_OUT);

    // ------------------------------------------------------------
    // Side registers and slot counters
    // ------------------------------------------------------------
    side_cfg_t        cfg_ff   [2];
    logic [9:0]       bcnt_ff  [2];
    logic [1:0]       fs_seen_ff;
    logic [1:0]       out_bit_ff;
    wire  [7:0]       slot_now [2];

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int s = 0; s < 2; s++) begin
                cfg_ff[s]  <= '{control: CTRL_RESET, in_slot: SLOT_RESET, out_slot: SLOT_RESET};
                bcnt_ff[s] <= BITCNT_MAX;
            end
            fs_seen_ff <= 2'h0;
            out_bit_ff <= 2'h0;
        end else begin
            for (int s = 0; s < 2; s++) begin
                // (R13) loads into the chosen side; (R15) only whole bytes write
                if (wr_ctrl && sel_side_ff == s[0]) begin
                    cfg_ff[s].control <= full_byte;
                end
                // (R2) low six bits of input slot byte
                if (wr_in && sel_side_ff == s[0]) begin
                    cfg_ff[s].in_slot <= full_byte[SLOT_W-1:0];
                end
                // (R3) low six bits of output slot byte
                if (wr_out && sel_side_ff == s[0]) begin
                    cfg_ff[s].out_slot <= full_byte[SLOT_W-1:0];
                end
                // (R14) restart on frame sync rise, saturate when lost
                if (bclk_rise[s]) begin
                    fs_seen_ff[s] <= fs_level[s];
                    out_bit_ff[s] <= tx_bit[s];
                    if (fs_level[s] && !fs_seen_ff[s]) begin
                        bcnt_ff[s] <= 10'h000;
                    end else if (bcnt_ff[s] != BITCNT_MAX) begin
                        bcnt_ff[s] <= bcnt_ff[s] + 10'h001;
                    end
                end
            end
        end
    end

    // (R14) slot width follows coding direction
    for (genvar g = 0; g < 2; g++) begin : g_slot
        assign slot_now[g]     = cfg_ff[g].control[CR_CODING_BIT] ? {1'b0, bcnt_ff[g][9:3]}
                                                                  : bcnt_ff[g][9:2];
        assign in_slot_hit[g]  = (bcnt_ff[g] != BITCNT_MAX) && (slot_now[g] == {2'b00, cfg_ff[g].in_slot});
        assign out_slot_hit[g] = (bcnt_ff[g] != BITCNT_MAX) && (slot_now[g] == {2'b00, cfg_ff[g].out_slot});
        assign side_cfg[g]     = cfg_ff[g];
    end

    // Idle side floats as well as the update window
    assign side_a_serial_out = out_bit_ff[SIDE_A];
    assign side_b_serial_out = out_bit_ff[SIDE_B];
    // (R9) float during update
    assign side_a_serial_oe  = out_slot_hit[SIDE_A] & ~cfg_ff[SIDE_A].control[CR_IDLE_BIT] & ~update_busy;
    assign side_b_serial_oe  = out_slot_hit[SIDE_B] & ~cfg_ff[SIDE_B].control[CR_IDLE_BIT] & ~update_busy;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    sequence seq_addr_byte;
        byte_done && state_ff == ST_ADDR;
    endsequence

    sequence seq_matched_write;
        seq_addr_byte ##0 addr_match ##1 state_ff == ST_CTRL;
    endsequence

    AST_ADDR_MISMATCH: assert property (seq_addr_byte ##0 !addr_match |=> (state_ff == ST_SKIP) [*2] or !sel_low) // R11
        else $error("mismatched address did not skip the write");
    AST_SIDE_PICK: assert property (seq_addr_byte |=> sel_side_ff == $past(full_byte[ACB_SIDE_BIT])) // R12
        else $error("side select not taken from bit six");
    AST_CTRL_LOAD: assert property (wr_ctrl |=> side_cfg[sel_side_ff].control == $past(full_byte)) // R13
        else $error("control byte not loaded into chosen side");
    AST_MATCH_BUSY: assert property (seq_matched_write |-> update_busy && !side_a_serial_oe && !side_b_serial_oe) // R9
        else $error("outputs not floated after address match");
    AST_IN_SLOT: assert property (wr_in |=> side_cfg[sel_side_ff].in_slot == $past(full_byte[5:0])) // R2
        else $error("input slot not the low six bits");
    AST_OUT_SLOT: assert property (wr_out |=> side_cfg[sel_side_ff].out_slot == $past(full_byte[5:0]) && !update_busy) // R3
        else $error("output slot not the low six bits");
    AST_FLOAT: assert property (update_busy |-> !side_a_serial_oe && !side_b_serial_oe) // R9
        else $error("sample output driven during update");
    AST_SELECT_GATE: assert property (!sel_low |=> bit_cnt_ff == 3'h0 && state_ff == ST_IDLE) // R4
        else $error("bits accepted with select high");
    AST_BIT_TAKE: assert property (take_bit && bit_cnt_ff != BIT_LAST |=> bit_cnt_ff == $past(bit_cnt_ff) + 3'h1) // R5
        else $error("serial clock rise did not take one bit");
    AST_PARTIAL_DROP: assert property (sel_rise && $past(bit_cnt_ff) != 3'h0 |-> $stable(side_cfg)) // R15
        else $error("cut byte changed a register");
    AST_SLOT_RESTART: assert property (bclk_rise[SIDE_A] && fs_level[SIDE_A] && !fs_seen_ff[SIDE_A]
                                       |=> bcnt_ff[SIDE_A] == 10'h000 ##1 bcnt_ff[SIDE_A] <= 10'h001) // R14
        else $error("slot count did not restart on frame sync");

endmodule : cfg_serial_port

// ==== inc/adpcm_cfg_pkg.sv ====
// Constants, types and states shared by the configuration serial port
package adpcm_cfg_pkg;

    // ------------------------------------------------------------
    // Byte and field layout
    // ------------------------------------------------------------
    localparam int          BYTE_W        = 8;
    localparam int          ADDR_W        = 6;
    localparam int          SLOT_W        = 6;
    localparam logic [2:0]  BIT_LAST      = 3'h7;
    localparam int          ACB_SIDE_BIT  = 6;
    localparam int          CR_CODING_BIT = 0;
    localparam int          CR_IDLE_BIT   = 5;

    // ------------------------------------------------------------
    // Side indices: side a is the X channel, chosen by a one
    // ------------------------------------------------------------
    localparam int          SIDE_A        = 1;
    localparam int          SIDE_B        = 0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  CTRL_RESET    = 8'h00;
    localparam logic [5:0]  SLOT_RESET    = 6'h00;

    // ------------------------------------------------------------
    // Pin synchroniser lanes
    // ------------------------------------------------------------
    localparam int          SY_SEL        = 0;
    localparam int          SY_SCLK       = 1;
    localparam int          SY_SDI        = 2;
    localparam int          SY_CLK_B      = 3;
    localparam int          SY_CLK_A      = 4;
    localparam int          SY_FS_B       = 5;
    localparam int          SY_FS_A       = 6;
    localparam int          SY_STRAP      = 7;
    localparam int          SYNC_W        = 13;
    localparam logic [12:0] SYNC_RESET    = 13'h0001;

    // ------------------------------------------------------------
    // Slot counting
    // ------------------------------------------------------------
    localparam int          BITCNT_W      = 10;
    localparam logic [9:0]  BITCNT_MAX    = 10'h3FF;

    typedef struct packed {
        logic [7:0] control;
        logic [5:0] in_slot;
        logic [5:0] out_slot;
    } side_cfg_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_CTRL = 3'b010,
        ST_IN   = 3'b011,
        ST_OUT  = 3'b100,
        ST_SKIP = 3'b101
    } port_state_t;

endpackage : adpcm_cfg_pkg

// ==== sim/host_model.sv ====
// Host microcontroller model that writes the three-wire configuration port
`timescale 1ns/1ps
module host_model
(
    input  wire logic sys_clk,
    output logic      cfg_select_n,
    output logic      cfg_serial_clk,
    output logic      serial_config_in
);
    // ------------------------------------------------------------
    // Idle pins
    // ------------------------------------------------------------
    // Clock stands still low outside frames
    initial begin
        cfg_select_n     = 1'b1;
        cfg_serial_clk   = 1'b0;
        serial_config_in = 1'b0;
    end

    // ------------------------------------------------------------
    // One write frame; nbits short of a byte multiple cuts a byte
    // ------------------------------------------------------------
    task automatic write_frame(input logic [31:0] data, input int nbits);
        int i;
        @(negedge sys_clk);
        cfg_select_n = 1'b0;
        repeat (16) @(negedge sys_clk);
        // lsb first, nbits bits from caller, whole bytes or not
        for (i = 0; i < nbits; i++) begin
            serial_config_in = data[i];
            repeat (64) @(negedge sys_clk);
            cfg_serial_clk = 1'b1;
            repeat (64) @(negedge sys_clk);
            cfg_serial_clk = 1'b0;
            // Hold over: show inverse, not a stale bit
            serial_config_in = ~data[i];
            repeat (16) @(negedge sys_clk);
        end
        repeat (64) @(negedge sys_clk);
        cfg_select_n = 1'b1;
        repeat (80) @(negedge sys_clk);
    endtask : write_frame
endmodule : host_model

// ==== sim/tb_top.sv ====
// Self-checking bench for the configuration serial port
`timescale 1ns/1ps
module tb_top
    import adpcm_cfg_pkg::*;
;
    logic            sys_clk = 1'b0;
    logic            arst_n  = 1'b0;
    logic            a_bclk  = 1'b0;
    logic            b_bclk  = 1'b0;
    logic            a_fs    = 1'b0;
    logic            b_fs    = 1'b0;
    logic [5:0]      strap   = 6'h2D;
    logic            cfg_select_n;
    logic            cfg_serial_clk;
    logic            serial_config_in;
    logic            a_out;
    logic            a_oe;
    logic            b_out;
    logic            b_oe;
    logic            busy;
    side_cfg_t [1:0] cfg;
    logic [1:0]      in_hit;
    logic [1:0]      out_hit;
    int              miscompares = 0;
    int              num_checks  = 0;
    int              n_a         = 0;
    int              ks[10]      = '{0, 3, 4, 167, 168, 175, 176, 336, 343, 344};

    // ------------------------------------------------------------
    // Clocks and instances
    // ------------------------------------------------------------
    always #2 sys_clk = ~sys_clk;
    always #16 a_bclk = ~a_bclk;
    always #16 b_bclk = ~b_bclk;
    always @(posedge a_bclk) n_a <= a_fs ? 0 : n_a + 1;

    host_model u_host (.sys_clk(sys_clk), .cfg_select_n(cfg_select_n), .cfg_serial_clk(cfg_serial_clk),
                       .serial_config_in(serial_config_in));

    cfg_serial_port u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .cfg_select_n(cfg_select_n),
        .cfg_serial_clk(cfg_serial_clk), .serial_config_in(serial_config_in), .strap_addr(strap),
        .side_a_bit_clock(a_bclk), .side_b_bit_clock(b_bclk), .side_a_frame_sync(a_fs),
        .side_b_frame_sync(b_fs), .side_a_tx_bit(1'b1), .side_b_tx_bit(1'b0),
        .side_a_serial_out(a_out), .side_a_serial_oe(a_oe), .side_b_serial_out(b_out),
        .side_b_serial_oe(b_oe), .side_cfg(cfg), .in_slot_hit(in_hit), .out_slot_hit(out_hit),
        .update_busy(busy));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        $display("checks %0d, miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : give_verdict

    // Hits read late in the bit period, before the next rise
    task automatic slot_at(input int k);
        logic [1:0] e_in;
        logic [1:0] e_out;
        e_out = {k / 8 == 21, k / 4 == 0};
        e_in  = {k / 8 == 42, k / 4 == 0};
        while (n_a != k) @(negedge a_bclk);
        #12;
        check(32'(out_hit), 32'(e_out), "out slot hit");
        check(32'(in_hit), 32'(e_in), "in slot hit");
        check(32'({a_oe, b_oe}), 32'(e_out), "output enable");
        check(32'({a_out, b_out}), 32'h2, "sample out bits");
    endtask : slot_at

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk) arst_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        check(32'(cfg[1]), 32'h0, "reset cfg a");
        check(32'(cfg[0]), 32'h0, "reset cfg b");
        check(32'({busy, a_oe, b_oe, in_hit, out_hit}), 32'h0, "reset outputs");
        // top two bits of slot bytes written as zero
        fork
            u_host.write_frame({8'h15, 8'h2A, 8'h01, 8'h6D}, 32);
            begin
                repeat (16 + 9 * 144) @(negedge sys_clk);
                check(32'({busy, a_oe, b_oe}), 32'h4, "busy floats outputs");
            end
        join
        check(32'(cfg[1]), 32'({8'h01, 6'h2A, 6'h15}), "side a four bytes");
        check(32'(cfg[0]), 32'h0, "side b untouched");
        check(32'(busy), 32'h0, "busy after write");
        $display("test four byte write done");
        u_host.write_frame({16'h0, 8'h04, 8'h2D}, 16);
        check(32'(cfg[0]), 32'({8'h04, 6'h00, 6'h00}), "side b two bytes");
        check(32'(cfg[1]), 32'({8'h01, 6'h2A, 6'h15}), "side a kept");
        $display("test two byte write done");
        // frame sync one bit clock wide
        @(negedge a_bclk);
        a_fs = 1'b1;
        b_fs = 1'b1;
        @(negedge a_bclk);
        a_fs = 1'b0;
        b_fs = 1'b0;
        foreach (ks[i]) slot_at(ks[i]);
        $display("test slot counting done");
        u_host.write_frame({8'h3F, 8'h3F, 8'h20, 8'h6C}, 32);
        check(32'(cfg[1]), 32'({8'h01, 6'h2A, 6'h15}), "address mismatch");
        $display("test address mismatch done");
        // Control byte sets idle and expand on side a
        u_host.write_frame({8'h00, 8'h07, 8'h20, 8'h6D}, 19);
        check(32'(cfg[1]), 32'({8'h20, 6'h2A, 6'h15}), "cut byte dropped");
        $display("test cut byte done");
        // frame sync one bit clock wide
        @(negedge a_bclk) a_fs = 1'b1;
        @(negedge a_bclk) a_fs = 1'b0;
        // Nibble slots now: output slot 21 starts at bit 84
        while (n_a != 84) @(negedge a_bclk);
        #12;
        check(32'(out_hit[SIDE_A]), 32'h1, "expand slot hit");
        check(32'(a_oe), 32'h0, "idle side floats");
        $display("test idle side done");
        give_verdict();
    end

    initial begin
        #300000;
        miscompares++;
        give_verdict();
    end
endmodule : tb_top
